/* inc/ors_pkg.sv */
// Package for the row scan, fuse store and reset/sleep control block.
// Assumes a 50 MHz aclk and a 32-bit AXI4-Lite register port.
package ors_pkg;
    // Command codes, carried in bits 15:8 of a command word
    localparam logic [7:0] CMD_BRIGHT_A   = 8'h01;
    localparam logic [7:0] CMD_BRIGHT_B   = 8'h02;
    localparam logic [7:0] CMD_CONVERTER  = 8'h03;
    localparam logic [7:0] CMD_DISPLAY    = 8'h10;
    localparam logic [7:0] CMD_MATRIX_DIR = 8'h11;
    localparam logic [7:0] CMD_ROW_SEL    = 8'h17;
    localparam logic [7:0] CMD_SLEEP      = 8'hf1;
    localparam logic [7:0] CMD_SOFT_RST   = 8'hf2;
    localparam logic [7:0] CMD_PAD_SHORT  = 8'hf3;
    localparam logic [7:0] CMD_FUSE_PROG  = 8'hf5;
    localparam logic [7:0] CMD_SEAL_CHECK = 8'hf7;
    // Register byte addresses
    localparam logic [7:0] ADDR_CMD       = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_ROW       = 8'h08;
    localparam logic [7:0] ADDR_SEAL      = 8'h0c;
    // Reset values and field positions
    localparam logic [7:0] RST_ROW_SEL    = 8'h02;
    localparam logic [7:0] RST_PAD_SHORT  = 8'h01;
    localparam logic [1:0] MODE_SINGLE    = 2'b10;
    localparam logic [1:0] MODE_DUAL      = 2'b11;
    localparam int         POS_ROW_DIR    = 4;
    localparam int         POS_VTURN      = 1;
    localparam int         POS_CMD_VALID  = 16;
    // Panel geometry
    localparam int         ROW_COUNT      = 72;
    localparam int         DUAL_STEPS     = 36;
    // Timing
    localparam int         CLK_HZ         = 50_000_000;
    localparam int         PROG_TIME_MS   = 50;
    localparam int         PROG_CYCLES    = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int         SRST_TIME_NS   = 200;
    localparam int         CLK_NS         = 1_000_000_000 / CLK_HZ;
    localparam int         SRST_CYCLES    = SRST_TIME_NS / CLK_NS;
    localparam int         FUSE_LOAD_CYC  = 4;
    // Control states
    typedef enum logic [2:0] {
        ST_FUSE_LOAD = 3'b000,
        ST_IDLE      = 3'b001,
        ST_SLEEP     = 3'b010,
        ST_PROGRAM   = 3'b011,
        ST_SOFT_RST  = 3'b100
    } ors_state_e;
endpackage

/* verilog/ors_ctrl.sv */
// Row scan sequencer, fuse store control and reset/sleep state machine.
// Assumes a single clock, synchronous inputs and an AXI4-Lite master.
// What this block does
// - active row grounded, idle rows pulled up
// - row mode 10b selects single scanning
// - direction 0 scans rows upward to 72
// - direction 1 scans downward from row 72
// - row mode 11b scans odd/even together
// - dual mode uses 36 steps, two rows
// - dual mode uses same direction bit
// - vertical turn bit flips display direction
// - reset exit loads fuses into flip-flops
// - command F5 data 1 starts programming
// - programming lasts 50 ms, ends itself
// - F3 bit 0 shorts pad, resets on
// - seal check resets when seal set
// - reset pin low grounds all drivers
// - reset exit starts scan clock within 200ns
// - F2 single byte, or F7 when sealed, resets device
// - command F1 enters sleep
// - commands 03h or 10h leave sleep
// - sleep grounds drivers, keeps registers
`timescale 1ns/1ns
module ors_ctrl #(
    parameter int ROWS        = ors_pkg::ROW_COUNT,
    parameter int PROG_CYCLES = ors_pkg::PROG_CYCLES,
    parameter int PARAM_BITS  = 16
) (
    // Clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 clk_en,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Fuse array
    input  wire logic [PARAM_BITS-1:0] antifuse_rd_data,
    output logic                      antifuse_power,
    output logic                      antifuse_blow,
    output logic [PARAM_BITS-1:0]     antifuse_wr_data,
    // Panel side
    output logic [ROWS-1:0]           row_sink,
    output logic                      prog_pad_short_enable,
    output logic                      scan_clock_out,
    output logic                      converter_on,
    output logic                      analog_on
);
    ////////////////////////////////////////////////////////////////////
    // Command framing
    ors_pkg::ors_state_e state;
    logic [1:0]            row_scan_kind;
    logic                  row_scan_direction;
    logic                  vertical_turn;
    logic [7:0]            display_ctrl;
    logic [7:0]            converter_ctrl;
    logic [7:0]            bright_a;
    logic [7:0]            bright_b;
    logic [PARAM_BITS-1:0] volatile_param_array;
    logic                  seal;
    logic [31:0]           prog_cnt;
    logic [6:0]            row_idx;
    logic [7:0]            srst_cnt;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_fire;
    logic        cmd_fire;
    logic [7:0]  cmd_code;
    logic [7:0]  cmd_data;
    logic        busy;
    // Busy states refuse commands; the bus still answers OKAY
    assign busy = (state == ors_pkg::ST_FUSE_LOAD)
               || (state == ors_pkg::ST_PROGRAM)
               || (state == ors_pkg::ST_SOFT_RST);
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign cmd_code = w_data[15:8];
    assign cmd_data = w_data[7:0];
    // atomic pair
    // Code and data arrive in one word, so a pair can never split
    assign cmd_fire = wr_fire && (aw_addr == ors_pkg::ADDR_CMD)
                   && w_data[ors_pkg::POS_CMD_VALID] && !busy;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else if (clk_en) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ors_pkg::ADDR_CMD
                              || aw_addr == ors_pkg::ADDR_SEAL)
                              ? 2'b00 : 2'b10;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else if (clk_en) begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'b00;
                if (s_axi_araddr == ors_pkg::ADDR_CMD) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (s_axi_araddr == ors_pkg::ADDR_STATUS) begin
                    s_axi_rdata <= {24'h00_0000, 3'b000, seal,
                                    prog_pad_short_enable, state};
                end else if (s_axi_araddr == ors_pkg::ADDR_ROW) begin
                    s_axi_rdata <= {16'h0000, 1'b0, row_idx,
                                    3'b000, row_scan_direction,
                                    1'b0, vertical_turn, row_scan_kind};
                end else if (s_axi_araddr == ors_pkg::ADDR_SEAL) begin
                    s_axi_rdata <= {16'h0000, volatile_param_array};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control state machine
    logic [2:0] load_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ors_pkg::ST_FUSE_LOAD;
            load_cnt <= 3'h0;
            prog_cnt <= 32'h0000_0000;
            srst_cnt <= 8'h00;
        end else if (clk_en) begin
            case (state)
                ors_pkg::ST_FUSE_LOAD: begin
                    if (load_cnt == 3'(ors_pkg::FUSE_LOAD_CYC - 1)) begin
                        state <= ors_pkg::ST_IDLE;
                    end else begin
                        load_cnt <= load_cnt + 3'h1;
                    end
                end
                ors_pkg::ST_PROGRAM: begin
                    if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
                        state <= ors_pkg::ST_IDLE;
                    end else begin
                        prog_cnt <= prog_cnt + 32'h1;
                    end
                end
                ors_pkg::ST_SOFT_RST: begin
                    if (srst_cnt == 8'(ors_pkg::SRST_CYCLES - 1)) begin
                        state    <= ors_pkg::ST_FUSE_LOAD;
                        load_cnt <= 3'h0;
                    end else begin
                        srst_cnt <= srst_cnt + 8'h1;
                    end
                end
                default: begin
                    if (cmd_fire) begin
                        if (cmd_code == ors_pkg::CMD_SOFT_RST) begin
                            state    <= ors_pkg::ST_SOFT_RST;
                            srst_cnt <= 8'h00;
                        end else if (cmd_code == ors_pkg::CMD_SEAL_CHECK
                                     && seal) begin
                            state    <= ors_pkg::ST_SOFT_RST;
                            srst_cnt <= 8'h00;
                        end else if (cmd_code == ors_pkg::CMD_FUSE_PROG
                                     && cmd_data == 8'h01) begin
                            state    <= ors_pkg::ST_PROGRAM;
                            prog_cnt <= 32'h0000_0000;
                        end else if (cmd_code == ors_pkg::CMD_SLEEP
                                     && cmd_data[0]) begin
                            state <= ors_pkg::ST_SLEEP;
                        end else if (cmd_code == ors_pkg::CMD_CONVERTER
                                  || cmd_code == ors_pkg::CMD_DISPLAY) begin
                            state <= ors_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command registers, defaults on pin or software reset
    logic soft_clear;
    assign soft_clear = (state == ors_pkg::ST_SOFT_RST);
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && soft_clear)) begin
            row_scan_kind         <= ors_pkg::RST_ROW_SEL[1:0];
            row_scan_direction    <= ors_pkg::RST_ROW_SEL[ors_pkg::POS_ROW_DIR];
            vertical_turn         <= 1'b0;
            display_ctrl          <= 8'h00;
            converter_ctrl        <= 8'h00;
            bright_a              <= 8'h00;
            bright_b              <= 8'h00;
            prog_pad_short_enable <= ors_pkg::RST_PAD_SHORT[0];
        end else if (clk_en && cmd_fire) begin
            if (cmd_code == ors_pkg::CMD_ROW_SEL) begin
                row_scan_kind      <= cmd_data[1:0];
                row_scan_direction <= cmd_data[ors_pkg::POS_ROW_DIR];
            end else if (cmd_code == ors_pkg::CMD_MATRIX_DIR) begin
                vertical_turn <= cmd_data[ors_pkg::POS_VTURN];
            end else if (cmd_code == ors_pkg::CMD_DISPLAY) begin
                display_ctrl <= cmd_data;
            end else if (cmd_code == ors_pkg::CMD_CONVERTER) begin
                converter_ctrl <= cmd_data;
            end else if (cmd_code == ors_pkg::CMD_BRIGHT_A) begin
                bright_a <= cmd_data;
            end else if (cmd_code == ors_pkg::CMD_BRIGHT_B) begin
                bright_b <= cmd_data;
            end else if (cmd_code == ors_pkg::CMD_PAD_SHORT) begin
                prog_pad_short_enable <= cmd_data[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fuse store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            volatile_param_array <= '0;
            antifuse_power       <= 1'b0;
            antifuse_blow        <= 1'b0;
            antifuse_wr_data     <= '0;
            seal                 <= 1'b0;
        end else if (clk_en) begin
            // array powered only while loading or blowing
            antifuse_power <= (state == ors_pkg::ST_FUSE_LOAD)
                           || (state == ors_pkg::ST_PROGRAM);
            antifuse_blow  <= (state == ors_pkg::ST_PROGRAM);
            if (state == ors_pkg::ST_FUSE_LOAD
                && load_cnt == 3'(ors_pkg::FUSE_LOAD_CYC - 1)) begin
                volatile_param_array <= antifuse_rd_data;
            end else if (cmd_fire && cmd_code == ors_pkg::CMD_BRIGHT_A) begin
                volatile_param_array[7:0] <= cmd_data;
            end else if (cmd_fire && cmd_code == ors_pkg::CMD_BRIGHT_B) begin
                volatile_param_array[15:8] <= cmd_data;
            end
            if (cmd_fire && cmd_code == ors_pkg::CMD_FUSE_PROG
                && cmd_data == 8'h01) begin
                antifuse_wr_data <= volatile_param_array;
            end
            if (state == ors_pkg::ST_PROGRAM
                && prog_cnt == 32'(PROG_CYCLES - 1)) begin
                seal <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Row scan sequencer
    logic running;
    logic dual;
    logic [6:0] last_step;
    assign running = (state == ors_pkg::ST_IDLE) && display_ctrl[0];
    assign dual = (row_scan_kind == ors_pkg::MODE_DUAL);
    assign last_step = dual ? 7'(ors_pkg::DUAL_STEPS - 1) : 7'(ROWS - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_idx  <= 7'h00;
            row_sink <= '0;
        end else if (clk_en) begin
            if (!running || row_scan_kind[1] == 1'b0) begin
                row_sink <= '0;
                row_idx  <= 7'h00;
            end else begin
                row_idx <= (row_idx >= last_step) ? 7'h00 : row_idx + 7'h1;
                row_sink <= '0;
                // sinks the active row (two rows in dual mode), others float high
                // vertical turn reverses the scan order
                if (dual) begin
                    if (row_scan_direction ^ vertical_turn) begin
                        row_sink[ROWS-1-2*row_idx] <= 1'b1;
                        row_sink[ROWS-2-2*row_idx] <= 1'b1;
                    end else begin
                        row_sink[2*row_idx]   <= 1'b1;
                        row_sink[2*row_idx+1] <= 1'b1;
                    end
                end else if (row_scan_direction ^ vertical_turn) begin
                    row_sink[ROWS-1-row_idx] <= 1'b1;
                end else begin
                    row_sink[row_idx] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Analog and clock outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_clock_out <= 1'b0;
            converter_on   <= 1'b0;
            analog_on      <= 1'b0;
        end else if (clk_en) begin
            scan_clock_out <= (state != ors_pkg::ST_SOFT_RST)
                              ? !scan_clock_out : 1'b0;
            converter_on <= (state == ors_pkg::ST_IDLE) && converter_ctrl[0];
            analog_on    <= (state == ors_pkg::ST_IDLE);
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Checks
    program_ends_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && state == ors_pkg::ST_PROGRAM
         && prog_cnt == 32'(PROG_CYCLES - 1))
        |=> state == ors_pkg::ST_IDLE)
        else $error("programming did not end");
    sleep_rows_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(state) == ors_pkg::ST_SLEEP && $past(clk_en) |-> row_sink == '0)
        else $error("rows driven in sleep");
    seal_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && cmd_fire && cmd_code == ors_pkg::CMD_SEAL_CHECK
         && !seal && state == ors_pkg::ST_IDLE)
        |=> state == ors_pkg::ST_IDLE)
        else $error("unsealed check acted");
    srst_start_a: assert property (@(posedge aclk)
        disable iff (!aresetn) clk_en && cmd_fire
        && cmd_code == ors_pkg::CMD_SOFT_RST |=> state == ors_pkg::ST_SOFT_RST)
        else $error("soft reset not started");
    srst_ends_a: assert property (@(posedge aclk)
        disable iff (!aresetn) clk_en && state == ors_pkg::ST_SOFT_RST
        && srst_cnt == 8'(ors_pkg::SRST_CYCLES - 1)
        |=> state == ors_pkg::ST_FUSE_LOAD) else $error("soft reset hung");
    sleep_entry_a: assert property (@(posedge aclk)
        disable iff (!aresetn) clk_en && cmd_fire && cmd_data[0]
        && cmd_code == ors_pkg::CMD_SLEEP |=> state == ors_pkg::ST_SLEEP)
        else $error("sleep not entered");
endmodule // ors_ctrl

/* bench/ors_fuse_model.sv */
// Behavioural anti-fuse array seen from the fuse store control.
// Assumes the control powers the array before it reads the cells.
`timescale 1ns/1ns
module ors_fuse_model #(
    parameter int              BITS = 16,
    parameter logic [BITS-1:0] INIT = '0
) (
    // Clock
    input  wire logic            aclk,
    // Array control
    input  wire logic            power,
    input  wire logic            blow,
    input  wire logic [BITS-1:0] wr_data,
    output logic      [BITS-1:0] rd_data
);
    logic [BITS-1:0] cells = INIT;
    logic [BITS-1:0] last  = '0;
    // Blown cells stay blown; an unpowered array shows a moving pattern
    always_ff @(posedge aclk) begin
        if (blow) begin
            cells <= cells | wr_data;
        end
        last <= power ? cells : ~last;
    end
    assign rd_data = power ? cells : last;
endmodule // ors_fuse_model

/* bench/tb_oled_row_scan_otp_state.sv */
// Self-checking bench for the row scan, fuse store and sleep control.
// Assumes ors_pkg and the fuse array model are compiled first.
`timescale 1ns/1ns
module tb_oled_row_scan_otp_state;
    localparam int          P = 20;
    localparam logic [15:0] FUSE_INIT = 16'h5a3c; // Arbitrary
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  s_axi_awaddr = '0;
    logic [7:0]  s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, antifuse_power, antifuse_blow, analog_on;
    logic        prog_pad_short_enable, scan_clock_out, converter_on;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] antifuse_rd_data, antifuse_wr_data;
    logic [71:0] row_sink;
    logic [7:0]  ba, bb;
    int          miscompares = 0;
    int          check_count = 0;
    int          seed = 30751;
    int          cnt;

    always #10 aclk = ~aclk;

    ors_ctrl #(.PROG_CYCLES(P)) uut (.aclk, .aresetn, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .antifuse_rd_data, .antifuse_power, .antifuse_blow,
        .antifuse_wr_data, .row_sink, .prog_pad_short_enable,
        .scan_clock_out, .converter_on, .analog_on);
    ors_fuse_model #(.INIT(FUSE_INIT)) fuse (.aclk, .power(antifuse_power),
        .blow(antifuse_blow), .wr_data(antifuse_wr_data),
        .rd_data(antifuse_rd_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [79:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic hang(input string m);
        miscompares++;
        $display("MISMATCH t=%0t no answer: %s", $time, m);
        end_sim();
    endtask
    // Ready is registered, so its level at the falling edge is its level
    // at the next rising edge, where the handshake completes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid === 1'b1;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ar, rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar || rv) s_axi_arvalid <= 1'b0;
            if (rv) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read");
    endtask
    task automatic cmd(input logic [7:0] c, d);
        wr(ors_pkg::ADDR_CMD, {15'h0000, 1'b1, c, d});
        chk(resp, 2'b00, "command answer");
    endtask
    task automatic wait_pwr(input logic lvl);
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (antifuse_power === lvl) return;
        end
        hang("fuse power");
    endtask
    task automatic toggles(input string m);
        logic t;
        @(negedge aclk);
        t = scan_clock_out;
        @(negedge aclk);
        chk(scan_clock_out, !t, m);
    endtask
    task automatic next_row(output logic [71:0] v);
        logic [71:0] o;
        o = row_sink;
        for (int n = 0; n < 30000; n++) begin
            @(negedge aclk);
            v = row_sink;
            if (v !== o && v !== '0) return;
        end
        hang("row step");
    endtask
    function automatic logic [71:0] step(logic [71:0] v, int k, bit up);
        return up ? (v << k) | (v >> (72 - k)) : (v >> k) | (v << (72 - k));
    endfunction
    task automatic scan(input logic [7:0] sel, turn, input bit up, int k);
        logic [71:0] a, b;
        cmd(ors_pkg::CMD_MATRIX_DIR, turn);
        cmd(ors_pkg::CMD_ROW_SEL, sel);
        next_row(a);
        next_row(a);
        next_row(b);
        chk($countones(b), k, "rows sinking together");
        chk(b, step(a, k, up), "scan order");
        $display("test scan %h turn %h done", sel, turn);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge aclk);
        chk(prog_pad_short_enable, 1'b1, "pad short at reset");
        chk({antifuse_power, scan_clock_out, converter_on, row_sink}, '0,
            "outputs in reset");
        @(posedge aclk);
        aresetn <= 1'b1;
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        rdr(ors_pkg::ADDR_SEAL);
        chk(rd[15:0], FUSE_INIT, "loaded parameters");
        toggles("scan clock after reset");
        rdr(8'h20);
        chk({resp, rd}, {2'b10, 32'h0}, "unmapped read");
        $display("test reset done");
        cmd(ors_pkg::CMD_SEAL_CHECK, 8'h00);
        cnt = 0;
        repeat (20) @(negedge aclk) cnt += antifuse_power;
        chk(cnt, 0, "unsealed check ignored");
        cmd(ors_pkg::CMD_SLEEP, 8'h01);
        cmd(ors_pkg::CMD_DISPLAY, 8'h01);
        rdr(ors_pkg::ADDR_STATUS);
        chk(rd[2:0], ors_pkg::ST_IDLE, "display leaves sleep");
        scan(8'h02, 8'h00, 1'b1, 1);
        scan(8'h12, 8'h00, 1'b0, 1);
        scan(8'h02, 8'h02, 1'b0, 1);
        scan(8'h03, 8'h00, 1'b1, 2);
        scan(8'h13, 8'h00, 1'b0, 2);
        cmd(ors_pkg::CMD_SLEEP, 8'h01);
        rdr(ors_pkg::ADDR_STATUS);
        chk(rd[2:0], ors_pkg::ST_SLEEP, "sleep state");
        repeat (2) @(negedge aclk);
        chk({analog_on, converter_on, row_sink}, '0, "sleep outputs");
        toggles("scan clock in sleep");
        cmd(ors_pkg::CMD_CONVERTER, 8'($random(seed)));
        rdr(ors_pkg::ADDR_STATUS);
        chk(rd[2:0], ors_pkg::ST_IDLE, "sleep left");
        $display("test sleep done");
        ba = 8'($random(seed)) & 8'h7f;
        bb = 8'($random(seed)) & 8'h7f;
        cmd(ors_pkg::CMD_BRIGHT_A, ba);
        cmd(ors_pkg::CMD_BRIGHT_B, bb);
        cmd(ors_pkg::CMD_PAD_SHORT, 8'h00);
        @(negedge aclk);
        chk(prog_pad_short_enable, 1'b0, "pad short opened");
        cmd(ors_pkg::CMD_FUSE_PROG, 8'h01);
        cnt = 0;
        repeat (200) @(negedge aclk) cnt += antifuse_blow;
        chk(cnt >= P - 2 && cnt <= P + 2, 1'b1, "program length");
        chk(antifuse_blow, 1'b0, "program ends alone");
        rdr(ors_pkg::ADDR_STATUS);
        chk(rd[4], 1'b1, "seal after program");
        cmd(ors_pkg::CMD_SOFT_RST, 8'h00);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        chk(prog_pad_short_enable, 1'b1, "soft reset defaults");
        rdr(ors_pkg::ADDR_SEAL);
        chk(rd[15:0], FUSE_INIT | {bb, ba}, "fuses blown");
        cmd(ors_pkg::CMD_DISPLAY, 8'h03);
        @(negedge aclk);
        chk(row_sink != '0, 1'b1, "display on");
        cmd(ors_pkg::CMD_SEAL_CHECK, 8'h00);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        chk({prog_pad_short_enable, row_sink}, {1'b1, 72'h0},
            "defaults after reset");
        $display("test program done");
        end_sim();
    end
endmodule // tb_oled_row_scan_otp_state
